//--- hw/dram_area_ctrl.sv
// DRAM area timing control: registers, access sequencer and refresh timer
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
module dram_area_ctrl (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [31:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [31:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire dram_area_pkg::acc_req_t acc_req,
  input  wire logic                   acc_valid,
  output logic                        acc_ready,
  output logic                        acc_done,
  input  wire logic                   ext_wait_n,
  output dram_area_pkg::mem_pins_t    mem,
  output logic                        dram_word,
  output logic                        refresh_enable,
  output logic                        refresh_kind,
  output logic                        irq
);
  import dram_area_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_PRECH, ST_ROW, ST_COL, ST_CLOSE, ST_GAP, ST_CS}
    seq_state_t;

  logic [15:0] wait2;
  logic [15:0] dctl;
  logic [15:0] rtcs;
  logic [7:0]  rcon;
  logic        istat;
  logic        imask;
  logic        cmf_armed;
  logic [7:0]  rcnt;
  logic        match;
  logic        aw_held;
  logic        w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  logic [15:0] wr_val;
  logic        wr_hit;
  logic [15:0] rd_val;
  logic        rd_hit;
  logic        wait_meta;
  logic        wait_sync;
  seq_state_t  state;
  acc_req_t    cur;
  logic [2:0]  cnt;
  logic [3:0]  cs_cnt;
  logic [2:0]  ras_len;
  logic        row_open;
  logic [11:0] open_row;
  logic [3:0]  col_bits;
  logic [23:0] word_addr;
  logic [11:0] row_addr;
  logic [11:0] col_addr;
  logic [11:0] req_row;
  logic        honour;
  logic [2:0]  col_len;
  logic [2:0]  tras_min;

  // Register index match on a byte address
  function automatic logic at(input logic [31:0] addr, input logic [31:0] idx);
    at = (addr[31:2] == idx[29:0]) && (addr[1:0] == 2'b00);
  endfunction : at

  // Cycle count for a two-bit wait code, 2 to 5 cycles
  function automatic logic [2:0] wait_len(input logic [1:0] code);
    wait_len = {1'b0, code} + 3'h2;
  endfunction : wait_len

  // Byte-lane merge of write data
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    merge = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  // Wait pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_meta <= 1'b0;
      wait_sync <= 1'b0;
    end else begin
      wait_meta <= ~ext_wait_n;
      wait_sync <= wait_meta;
    end
  end

  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;

  // Write decode
  always_comb begin
    wr_hit = 1'b1;
    wr_val = 16'h0000;
    if (at(aw_addr, WAIT2_IDX)) begin
      wr_val = merge(wait2, w_data, w_strb) & WAIT2_MASK;
    end else if (at(aw_addr, DCTL_IDX)) begin
      wr_val = merge(dctl, w_data, w_strb) & DCTL_MASK;
    end else if (at(aw_addr, RTCS_IDX)) begin
      wr_val = merge(rtcs, w_data, w_strb) & RTCS_MASK;
    end else if (at(aw_addr, RCNT_IDX) || at(aw_addr, RCON_IDX)) begin
      wr_val = merge({8'h00, at(aw_addr, RCON_IDX) ? rcon : rcnt}, w_data, w_strb);
    end else if (at(aw_addr, ISTAT_IDX) || at(aw_addr, IMASK_IDX)) begin
      wr_val = merge(16'h0000, w_data, w_strb);
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait2 <= WAIT2_RST;
      dctl  <= DCTL_RST;
      rcon  <= RCON_RST;
      imask <= 1'b0;
    end else if (wr_go) begin
      if (at(aw_addr, WAIT2_IDX)) wait2 <= wr_val;
      if (at(aw_addr, DCTL_IDX)) dctl <= wr_val;
      if (at(aw_addr, RCON_IDX)) rcon <= wr_val[7:0];
      if (at(aw_addr, IMASK_IDX)) imask <= wr_val[0];
    end
  end

  // Refresh control bits and compare flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rtcs      <= RTCS_RST;
      cmf_armed <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready && at(s_axi_araddr, RTCS_IDX) && rtcs[CMF_BIT]) begin
        cmf_armed <= 1'b1;
      end
      if (wr_go && at(aw_addr, RTCS_IDX)) begin
        rtcs[COMPARE_MATCH_IRQ_EN_BIT:0] <= wr_val[COMPARE_MATCH_IRQ_EN_BIT:0];
        if (cmf_armed && !wr_val[CMF_BIT]) begin
          rtcs[CMF_BIT] <= 1'b0;
          cmf_armed     <= 1'b0;
        end
      end
      if (match) begin
        rtcs[CMF_BIT] <= 1'b1;
      end
    end
  end

  // Sticky event status, write one to clear, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat <= 1'b0;
    end else if (match) begin
      istat <= 1'b1;
    end else if (wr_go && at(aw_addr, ISTAT_IDX) && wr_val[0]) begin
      istat <= 1'b0;
    end
  end

  assign irq = (istat && imask) || (rtcs[CMF_BIT] && rtcs[COMPARE_MATCH_IRQ_EN_BIT]);

  // Read decode
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 16'h0000;
    if (at(s_axi_araddr, WAIT2_IDX)) begin
      rd_val = wait2;
    end else if (at(s_axi_araddr, DCTL_IDX)) begin
      rd_val = dctl;
    end else if (at(s_axi_araddr, RTCS_IDX)) begin
      rd_val = rtcs;
    end else if (at(s_axi_araddr, RCNT_IDX)) begin
      rd_val = {8'h00, rcnt};
    end else if (at(s_axi_araddr, RCON_IDX)) begin
      rd_val = {8'h00, rcon};
    end else if (at(s_axi_araddr, ISTAT_IDX)) begin
      rd_val = {15'h0000, istat};
    end else if (at(s_axi_araddr, IMASK_IDX)) begin
      rd_val = {15'h0000, imask};
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Read data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_val};
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Refresh interval timer
  refresh_timer u_timer (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clk_sel   (rtcs[CKS_LSB+2:CKS_LSB]),
    .cnt_wr    (wr_go && at(aw_addr, RCNT_IDX)),
    .cnt_wdata (wr_val[7:0]),
    .const_val (rcon),
    .count     (rcnt),
    .match     (match)
  );

  assign refresh_enable = rtcs[REFRESH_ENABLE_BIT];
  assign refresh_kind   = rtcs[RMD_BIT];

  // Address multiplexing for width and column count
  assign dram_word = dctl[SZ_BIT];
  assign col_bits  = BASE_COL_BITS + {2'b00, dctl[AMX_LSB+1:AMX_LSB]};
  assign word_addr = cur.addr >> dctl[SZ_BIT];
  assign row_addr  = 12'(word_addr >> col_bits);
  assign col_addr  = 12'(word_addr & ((24'h1 << col_bits) - 24'h1));
  assign req_row   = 12'((acc_req.addr >> dctl[SZ_BIT]) >> col_bits);
  assign tras_min  = TRAS_CYC_0 + {1'b0, dctl[TRAS_LSB+1:TRAS_LSB]};

  // Column phase length and wait honouring per kind
  always_comb begin
    col_len = wait_len(dctl[DWR_LSB+1:DWR_LSB]);
    honour  = dctl[DWR_LSB+1];
    if (cur.kind == KIND_DRAM_DMA) begin
      col_len = wait_len(wait2[DDW_LSB+1:DDW_LSB]);
      honour  = wait2[DDW_LSB+1];
    end else if (cur.write) begin
      col_len = wait_len(dctl[DWW_LSB+1:DWW_LSB]);
      honour  = dctl[DWW_LSB+1];
    end
  end

  assign acc_ready = (state == ST_IDLE);

  // Access sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= ST_IDLE;
      cur      <= '0;
      cnt      <= 3'h0;
      cs_cnt   <= 4'h0;
      ras_len  <= 3'h0;
      row_open <= 1'b0;
      open_row <= 12'h000;
      acc_done <= 1'b0;
      mem      <= '{ras_n: 1'b1, cas_n: 1'b1, cs_n: 1'b1, we_n: 1'b1, addr: 12'h000};
    end else begin
      acc_done <= 1'b0;
      if (!mem.ras_n && ras_len != 3'h7) ras_len <= ras_len + 3'h1;
      case (state)
        ST_IDLE: begin
          if (acc_valid) begin
            cur <= acc_req;
            cnt <= 3'h1;
            if (acc_req.kind == KIND_CS_DMA) begin
              state     <= ST_CS;
              cs_cnt    <= 4'h0;
              mem.cs_n  <= 1'b0;
              mem.we_n  <= ~acc_req.write;
            end else if (row_open && req_row == open_row && dctl[BE_BIT]) begin
              state    <= ST_COL;
              mem.we_n <= ~acc_req.write;
            end else if (row_open) begin
              state     <= ST_CLOSE;
            end else begin
              state <= ST_PRECH;
            end
          end
        end
        ST_CLOSE: begin
          if (ras_len >= tras_min) begin
            mem.ras_n <= 1'b1;
            row_open  <= 1'b0;
            state     <= ST_PRECH;
            cnt       <= 3'h1;
          end
        end
        ST_PRECH: begin
          if (cnt >= (dctl[TPC_BIT] ? PRECH_CYC_1 : PRECH_CYC_0)) begin
            mem.ras_n <= 1'b0;
            mem.addr  <= row_addr;
            ras_len   <= 3'h0;
            open_row  <= row_addr;
            state     <= ST_ROW;
            cnt       <= 3'h1;
          end else begin
            cnt <= cnt + 3'h1;
          end
        end
        ST_ROW: begin
          if (cnt >= (dctl[RCD_BIT] ? RCD_CYC_1 : RCD_CYC_0)) begin
            mem.we_n  <= ~cur.write;
            mem.addr  <= col_addr;
            mem.cas_n <= 1'b0;
            state     <= ST_COL;
            cnt       <= 3'h1;
          end else begin
            cnt <= cnt + 3'h1;
          end
        end
        ST_COL: begin
          mem.addr <= col_addr;
          if (mem.cas_n) begin
            mem.cas_n <= 1'b0; // Page hit opens its column here
            cnt       <= 3'h1;
          end else if (cnt >= col_len && !(honour && wait_sync)) begin
            mem.cas_n <= 1'b1;
            mem.we_n  <= 1'b1;
            acc_done  <= 1'b1;
            cnt       <= 3'h1;
            if (dctl[ROW_DOWN_MODE_BIT]) begin
              row_open <= 1'b1;
              state    <= dctl[DIW_BIT] ? ST_GAP : ST_IDLE;
            end else begin
              row_open <= 1'b0; // Row closes once its strobe time is met
              state    <= ST_CLOSE;
            end
          end else if (cnt < col_len) begin
            cnt <= cnt + 3'h1;
          end
        end
        ST_GAP: begin
          state <= ST_IDLE;
        end
        ST_CS: begin
          if (cs_cnt >= wait2[DSW_LSB+3:DSW_LSB]
              && !(wait2[DSW_LSB+3:DSW_LSB] != 4'h0 && wait_sync)) begin
            mem.cs_n <= 1'b1;
            mem.we_n <= 1'b1;
            acc_done <= 1'b1;
            state    <= ST_IDLE;
          end else if (cs_cnt != 4'hf) begin
            cs_cnt <= cs_cnt + 4'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if (state == ST_CLOSE && ras_len >= tras_min && !row_open) begin
        state <= dctl[DIW_BIT] ? ST_GAP : ST_IDLE;
      end
    end
  end

endmodule : dram_area_ctrl

//--- hw/dram_area_pkg.sv
// Shared constants and carrier types of the DRAM area timing control block
package dram_area_pkg;

  // Register indices; byte address is four times the index
  localparam logic [31:0] WAIT2_IDX     = 32'hffff8626;
  localparam logic [31:0] DCTL_IDX      = 32'hffff862a;
  localparam logic [31:0] RTCS_IDX      = 32'hffff862c;
  localparam logic [31:0] RCNT_IDX      = 32'hffff862e;
  localparam logic [31:0] RCON_IDX      = 32'hffff8630;
  localparam logic [31:0] ISTAT_IDX     = 32'hffff8640;
  localparam logic [31:0] IMASK_IDX     = 32'hffff8641;

  // Wait control fields
  localparam int          DDW_LSB       = 4;
  localparam int          DSW_LSB       = 0;
  localparam logic [15:0] WAIT2_MASK    = 16'h003f;
  localparam logic [15:0] WAIT2_RST     = 16'h000f;

  // DRAM control fields
  localparam int          TPC_BIT       = 15;
  localparam int          RCD_BIT       = 14;
  localparam int          TRAS_LSB      = 12;
  localparam int          DWW_LSB       = 10;
  localparam int          DWR_LSB       = 8;
  localparam int          DIW_BIT       = 7;
  localparam int          BE_BIT        = 5;
  localparam int          ROW_DOWN_MODE_BIT      = 4;
  localparam int          SZ_BIT        = 2;
  localparam int          AMX_LSB       = 0;
  localparam logic [15:0] DCTL_MASK     = 16'hffb7;
  localparam logic [15:0] DCTL_RST      = 16'h0000;

  // Refresh control/status fields
  localparam int          CMF_BIT       = 6;
  localparam int          COMPARE_MATCH_IRQ_EN_BIT      = 5;
  localparam int          CKS_LSB       = 2;
  localparam int          REFRESH_ENABLE_BIT      = 1;
  localparam int          RMD_BIT       = 0;
  localparam logic [15:0] RTCS_MASK     = 16'h007f;
  localparam logic [15:0] RTCS_RST      = 16'h0000;
  localparam logic [7:0]  RCNT_RST      = 8'h00;
  localparam logic [7:0]  RCON_RST      = 8'h00;

  // Timing in half cycles, whole-cycle counts round up
  localparam int          TPC_HALF_0    = 3;
  localparam int          TPC_HALF_1    = 5;
  localparam int          TRAS_HALF_0   = 5;
  localparam logic [2:0]  PRECH_CYC_0   = 3'((TPC_HALF_0 + 1) / 2);
  localparam logic [2:0]  PRECH_CYC_1   = 3'((TPC_HALF_1 + 1) / 2);
  localparam logic [2:0]  TRAS_CYC_0    = 3'((TRAS_HALF_0 + 1) / 2);
  localparam logic [2:0]  RCD_CYC_0     = 3'h1;
  localparam logic [2:0]  RCD_CYC_1     = 3'h2;
  localparam logic [3:0]  BASE_COL_BITS = 4'h9;

  // AXI response codes
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  // Access kinds on the request port
  typedef enum logic [1:0] {KIND_DRAM, KIND_DRAM_DMA, KIND_CS_DMA} acc_kind_t;

  // Access request from the bus core
  typedef struct packed {
    acc_kind_t   kind;
    logic        write;
    logic [23:0] addr;
  } acc_req_t;

  // External memory strobes and address
  typedef struct packed {
    logic        ras_n;
    logic        cas_n;
    logic        cs_n;
    logic        we_n;
    logic [11:0] addr;
  } mem_pins_t;

endpackage : dram_area_pkg

//--- hw/refresh_timer.sv
// Refresh interval timer: prescaler, counter and compare match
`timescale 1ns/100ps
module refresh_timer (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] clk_sel,
  input  wire logic       cnt_wr,
  input  wire logic [7:0] cnt_wdata,
  input  wire logic [7:0] const_val,
  output logic      [7:0] count,
  output logic            match
);
  import dram_area_pkg::*;

  logic [11:0] prescale;
  logic [11:0] tap;
  logic        tick;

  // Divider tap for each clock select code
  function automatic logic [11:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'h1:    div_mask = 12'h001;
      3'h2:    div_mask = 12'h007;
      3'h3:    div_mask = 12'h01f;
      3'h4:    div_mask = 12'h07f;
      3'h5:    div_mask = 12'h1ff;
      3'h6:    div_mask = 12'h7ff;
      3'h7:    div_mask = 12'hfff;
      default: div_mask = 12'h000;
    endcase
  endfunction : div_mask

  // Free running prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale <= 12'h000;
    end else begin
      prescale <= prescale + 12'h001;
    end
  end

  assign tap  = div_mask(clk_sel);
  assign tick = (clk_sel != 3'h0) && ((prescale & tap) == tap);

  // Count up, clear and flag on compare match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= RCNT_RST;
      match <= 1'b0;
    end else begin
      match <= 1'b0;
      if (cnt_wr) begin
        count <= cnt_wdata;
      end else if (tick) begin
        if (count == const_val) begin
          count <= 8'h00;
          match <= 1'b1;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end

endmodule : refresh_timer

//--- verification/dram_area_monitor.sv
// Port checker for the DRAM area timing control block
`timescale 1ns/100ps
module dram_area_monitor
  import dram_area_pkg::*;
(
  input wire logic      aclk,
  input wire logic      aresetn,
  input wire logic      s_axi_bvalid,
  input wire logic      s_axi_bready,
  input wire logic      s_axi_rvalid,
  input wire logic      s_axi_rready,
  input wire logic      acc_valid,
  input wire logic      acc_ready,
  input wire logic      acc_done,
  input wire mem_pins_t mem
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped early");
  precharge_min_a: assert property ($rose(mem.ras_n) |=> mem.ras_n)
    else $error("row precharge too short");
  row_assert_a: assert property ($fell(mem.ras_n) |-> !mem.ras_n [*3])
    else $error("row strobe low too short");
  row_col_a: assert property ($fell(mem.cas_n) |-> !$past(mem.ras_n))
    else $error("column strobe before row delay");
  col_len_a: assert property ($fell(mem.cas_n) |-> !mem.cas_n [*2])
    else $error("column strobe too short");
  done_pulse_a: assert property (acc_done |=> !acc_done)
    else $error("done pulse longer than one cycle");
  done_bound_a: assert property (acc_valid && acc_ready |-> ##[2:200] acc_done)
    else $error("access never finished");
endmodule : dram_area_monitor

bind dram_area_ctrl dram_area_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .acc_valid(acc_valid), .acc_ready(acc_ready),
  .acc_done(acc_done), .mem(mem)
);

//--- verification/mem_device_model.sv
// External memory model that can stretch accesses with its wait pin
`timescale 1ns/100ps
module mem_device_model
  import dram_area_pkg::*;
(
  input wire logic      aclk,
  input wire mem_pins_t mem,
  input wire logic      slow,
  output logic          ext_wait_n
);
  logic [2:0] low_cnt;
  logic       strobe_low;
  assign strobe_low = !mem.cas_n || !mem.cs_n;
  // Counts the cycles a strobe has been low
  always @(posedge aclk) begin
    if (!strobe_low)
      low_cnt <= 3'h0;
    else if (low_cnt != 3'h4)
      low_cnt <= low_cnt + 3'h1;
  end
  // Slow mode pulls wait for the first four cycles of a strobe
  assign ext_wait_n = !(slow && strobe_low && low_cnt != 3'h4); // Pulled up when released
endmodule : mem_device_model

//--- verification/dram_area_timing_control_test.sv
// Self-checking bench of the DRAM area timing control block
`timescale 1ns/100ps
module dram_area_timing_control_test;
  import dram_area_pkg::*;
  localparam logic [31:0] A_WAIT = WAIT2_IDX << 2;
  localparam logic [31:0] A_DCTL = DCTL_IDX << 2;
  localparam logic [31:0] A_RTCS = RTCS_IDX << 2;
  localparam logic [31:0] A_RCON = RCON_IDX << 2;
  localparam logic [31:0] A_ISTAT = ISTAT_IDX << 2;
  localparam logic [31:0] A_IMASK = IMASK_IDX << 2;
  logic        aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic        awready, wready, arready, acc_valid, acc_ready, acc_done, ext_wait_n;
  logic        irq, slow, dram_word, refresh_enable, refresh_kind;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [1:0]  bresp, rresp, r;
  acc_req_t    acc_req;
  mem_pins_t   mem;
  int          bad_count, checks, nc, ncs, npre, nrc, p0;

  dram_area_ctrl u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .acc_req(acc_req), .acc_valid(acc_valid), .acc_ready(acc_ready),
    .acc_done(acc_done), .ext_wait_n(ext_wait_n), .mem(mem), .dram_word(dram_word),
    .refresh_enable(refresh_enable), .refresh_kind(refresh_kind), .irq(irq)
  );
  mem_device_model u_mem (.aclk(aclk), .mem(mem), .slow(slow), .ext_wait_n(ext_wait_n));

  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Register write; ready is sampled mid-cycle, where it equals its edge value
  task automatic wr(input logic [31:0] a, input logic [15:0] v);
    int   n;
    logic ha, hw, hb;
    n = 0;
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
      n++;
    end while (!hb && n < 50);
    @(posedge aclk);
    chk("write answer", 32'h1, {31'h0, hb});
  endtask : wr

  // Register read
  task automatic rd(input logic [31:0] a);
    int   n;
    logic ha, hr;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
      n++;
    end while (!hr && n < 50);
    @(posedge aclk);
    chk("read answer", 32'h1, {31'h0, hr});
  endtask : rd

  // One access, counting strobe cycles until done
  task automatic acc(input acc_kind_t k, input logic w);
    int   n;
    logic hit, rs;
    nc = 0;
    ncs = 0;
    npre = 0;
    nrc = 0;
    rs = 0;
    n = 0;
    acc_req <= '{kind: k, write: w, addr: 24'h000123};
    acc_valid <= 1'b1;
    do begin
      @(negedge aclk);
      hit = acc_ready;
      @(posedge aclk);
      if (hit) acc_valid <= 1'b0;
      n++;
    end while (!hit && n < 20);
    do begin
      @(negedge aclk);
      if (!mem.cas_n) nc++;
      if (!mem.cs_n) ncs++;
      if (!mem.ras_n) rs = 1;
      else if (!rs) npre++;
      if (!mem.ras_n && mem.cas_n && nc == 0) nrc++;
      hit = acc_done;
      @(posedge aclk);
      n++;
    end while (!hit && n < 220);
    chk("access done", 32'h1, {31'h0, hit});
  endtask : acc

  // Reset values, reserved bits and an unmapped address
  task automatic t_regs;
    rd(A_WAIT);
    chk("wait reset", 32'h0000000f, d);
    rd(A_DCTL);
    chk("dram reset", 32'h0, d);
    rd(A_RTCS);
    chk("refresh reset", 32'h0, d);
    wr(A_WAIT, 16'hffff);
    rd(A_WAIT);
    chk("wait reserved", 32'h0000003f, d);
    wr(A_DCTL, 16'hffff);
    rd(A_DCTL);
    chk("dram reserved", 32'h0000ffb7, d);
    chk("width pin", 32'h1, {31'h0, dram_word});
    wr(A_RTCS, 16'hff80);
    rd(A_RTCS);
    chk("refresh reserved", 32'h0, d);
    rd(32'h00000000);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
  endtask : t_regs

  // Column lengths for every wait code
  task automatic t_len;
    for (int c = 0; c < 4; c++) begin
      wr(A_DCTL, (16'(c) << DWR_LSB) | (16'(c) << DWW_LSB));
      wr(A_WAIT, 16'(c) << DDW_LSB);
      acc(KIND_DRAM, 1'b0);
      chk("read column", 32'(c + 2), 32'(nc));
      acc(KIND_DRAM, 1'b1);
      chk("write column", 32'(c + 2), 32'(nc));
      acc(KIND_DRAM_DMA, 1'b0);
      chk("dma column", 32'(c + 2), 32'(nc));
    end
  endtask : t_len

  // Precharge, row delay and down mode
  task automatic t_row;
    wr(A_DCTL, 16'h0000);
    acc(KIND_DRAM, 1'b0);
    p0 = npre;
    chk("row delay short", 32'h1, 32'(nrc));
    wr(A_DCTL, (16'h1 << TPC_BIT) | (16'h1 << RCD_BIT));
    acc(KIND_DRAM, 1'b0);
    chk("row delay long", 32'h2, 32'(nrc));
    chk("precharge long", 32'(p0 + 1), 32'(npre));
    wr(A_DCTL, 16'h1 << ROW_DOWN_MODE_BIT);
    acc(KIND_DRAM, 1'b0);
    @(negedge aclk);
    chk("row held down", 32'h0, {31'h0, mem.ras_n});
    @(posedge aclk);
    wr(A_DCTL, (16'h1 << ROW_DOWN_MODE_BIT) | (16'h1 << BE_BIT));
    acc(KIND_DRAM, 1'b0);
    chk("page hit", 32'h0, 32'(npre));
  endtask : t_row

  // Chip-select single transfers with and without waits
  task automatic t_cs;
    slow <= 1'b1;
    wr(A_WAIT, 16'h0000);
    acc(KIND_CS_DMA, 1'b0);
    chk("cs no wait", 32'h1, 32'(ncs));
    slow <= 1'b0;
    wr(A_WAIT, 16'h0002);
    acc(KIND_CS_DMA, 1'b0);
    chk("cs two waits", 32'h3, 32'(ncs));
    slow <= 1'b1;
    acc(KIND_CS_DMA, 1'b0);
    chk("cs stretched", 32'h1, {31'h0, ncs > 3});
    slow <= 1'b0;
  endtask : t_cs

  // Compare match flag, its enable and the status interrupt
  task automatic t_irq;
    int n;
    wr(A_IMASK, 16'h0000);
    wr(A_RCON, 16'h0003);
    wr(A_RTCS, 16'h0007);
    chk("refresh pins", 32'h3, {30'h0, refresh_enable, refresh_kind});
    n = 0;
    do begin
      rd(A_RTCS);
      n++;
    end while (d[CMF_BIT] !== 1'b1 && n < 40);
    chk("match flag", 32'h1, {31'h0, d[CMF_BIT]});
    chk("irq blocked", 32'h0, {31'h0, irq});
    wr(A_RTCS, 16'h0060);
    chk("irq enabled", 32'h1, {31'h0, irq});
    rd(A_RTCS);
    wr(A_RTCS, 16'h0020);
    rd(A_RTCS);
    chk("flag cleared", 32'h00000020, d);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(A_IMASK, 16'h0001);
    chk("status irq", 32'h1, {31'h0, irq});
    wr(A_ISTAT, 16'h0001);
    chk("status cleared", 32'h0, {31'h0, irq});
  endtask : t_irq

  // Verdict and end of run
  task automatic print_verdict;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Watchdog over the whole run
  initial begin
    #2400000;
    bad_count++;
    print_verdict();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, acc_valid, slow} = '0;
    {awaddr, wdata, araddr} = '0;
    acc_req = '0;
    bad_count = 0;
    checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_len();
    t_row();
    t_cs();
    t_irq();
    print_verdict();
  end
endmodule : dram_area_timing_control_test
